// *** verilog/desc_pkg.sv ***
// Constants shared by the interrupt split descriptor executor
package desc_pkg;
   // Register port map: descriptor words, then engine status
   localparam int DESC_WORDS = 8;
   localparam logic [3:0] ADDR_ENGINE = 4'h8;
   localparam int W_DW0 = 0;
   localparam int W_DW1 = 1;
   localparam int W_DW2 = 2;
   localparam int W_DW3 = 3;
   localparam int W_DW4 = 4;
   localparam int W_DW5 = 5;
   localparam logic [31:0] DESC_RESET = 32'h0;

   // Word 0 fields
   localparam int VALID_POS = 0;
   localparam int MAXPKT_LSB = 18;
   localparam int EP_LOW_POS = 31;
   // Word 1 fields
   localparam int EP_HIGH_LSB = 0;
   localparam int DEV_LSB = 3;
   localparam int TOKEN_LSB = 10;
   localparam int TTYPE_LSB = 12;
   localparam int SPLIT_POS = 14;
   localparam int SPEED_END_LSB = 16;
   localparam int HUB_PORT_LSB = 18;
   localparam int HUB_ADDR_LSB = 25;
   // Word 2 fields
   localparam int RATE_LSB = 3;
   localparam int BUF_ADDR_LSB = 8;
   // Word 3 fields
   localparam int DONE_CNT_LSB = 0;
   localparam int CERR_LSB = 23;
   localparam int TOGGLE_POS = 25;
   localparam int PHASE_POS = 27;
   localparam int XERR_POS = 28;
   localparam int BABBLE_POS = 29;
   localparam int HALT_POS = 30;
   localparam int ACTIVE_POS = 31;
   // Word 4 fields: start split mask and eight 3-bit results
   localparam int SS_MASK_LSB = 0;
   localparam int RESULT_LSB = 8;
   localparam int RESULT_W = 3;
   localparam int RES_XERR_BIT = 0;
   localparam int RES_BABBLE_BIT = 1;
   localparam int RES_UNDERRUN_BIT = 2;
   // Word 5 fields: complete split mask
   localparam int CS_MASK_LSB = 0;

   // Encodings
   localparam logic [1:0] TTYPE_INTR = 2'h3;
   localparam logic [1:0] TOKEN_OUT = 2'h0;
   localparam logic [1:0] TOKEN_IN = 2'h1;
   localparam logic [1:0] CERR_NONE = 2'h0;
   localparam logic [2:0] RES_ACK = 3'h0;
   localparam logic [2:0] RES_NAK = 3'h1;
   localparam logic [2:0] RES_NYET = 3'h2;
   localparam logic [2:0] RES_STALL = 3'h3;
   localparam logic [2:0] RES_XERR = 3'h4;
   localparam logic [2:0] RES_BABBLE = 3'h5;
   localparam logic [2:0] RES_UNDERRUN = 3'h6;
endpackage

// *** verilog/poll_match.sv ***
// Poll interval and phase match for the millisecond frame number
`timescale 1ns/10ps
module poll_match
   import desc_pkg::*;
(
   input wire logic [4:0] rate,
   input wire logic [4:0] frame,
   output logic hit
);
   logic [4:0] agree;

   // The highest set rate bit gives the period; lower bits give the phase
   genvar i;
   generate
      for (i = 0; i < 5; i = i + 1)
      begin : g_bit
         if (i == 4)
         begin : g_top
            assign agree[i] = 1'b1;
         end
         else
         begin : g_low
            assign agree[i] = ~(|rate[4:i+1]) | (frame[i] == rate[i]);
         end
      end
   endgenerate

   // Zero rate matches every frame
   assign hit = &agree;
endmodule // poll_match

// *** verilog/split_intr_exec.sv ***
// Interrupt descriptor executor for split and high-speed transactions
`timescale 1ns/10ps
module split_intr_exec
   import desc_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [3:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [31:0] REG_RDATA,
   input wire logic SOF,
   input wire logic [2:0] UFRAME,
   input wire logic [4:0] FRAME_MS,
   output logic XFER_REQ,
   output logic XFER_SPLIT,
   output logic XFER_PHASE,
   output logic [6:0] XFER_HUB,
   output logic [6:0] XFER_PORT,
   output logic [1:0] XFER_SPEED_END,
   output logic [1:0] XFER_PID,
   output logic [6:0] XFER_DEV,
   output logic [3:0] XFER_EP,
   output logic XFER_TOGGLE,
   output logic [10:0] XFER_MAXLEN,
   output logic [15:0] XFER_BUF_ADDR,
   input wire logic XFER_DONE,
   input wire logic [2:0] XFER_RESULT,
   input wire logic [11:0] XFER_COUNT
);
   typedef enum logic [0:0] {ST_IDLE, ST_WAIT} state_e;

   typedef struct packed {
      state_e state;
      logic [DESC_WORDS-1:0][31:0] desc;
      logic [31:0] rd_data;
      logic [2:0] slot;
      logic [2:0] last_res;
      logic req;
      logic split;
      logic phase;
      logic [6:0] hub;
      logic [6:0] port;
      logic [1:0] speed_end;
      logic [1:0] pid;
      logic [6:0] dev;
      logic [3:0] ep;
      logic toggle;
      logic [10:0] maxlen;
      logic [15:0] buf_addr;
   } state_s;

   state_s s;
   state_s next_s;
   logic poll_hit;

   // Decoded fields of the stored descriptor
   logic valid;
   logic active;
   logic is_split;
   logic cs_due;
   logic [1:0] ttype;
   logic [7:0] ss_mask;
   logic [7:0] cs_mask;
   logic [7:0] due_mask;
   logic [6:0] hub_addr_field;
   logic [6:0] hub_port_field;
   logic [1:0] speed_end_field;
   logic [1:0] token_field;
   logic [15:0] payload_buffer_addr;
   logic data_toggle_bit;
   logic split_phase_flag;
   logic [4:0] poll_rate;

   // Issue fields under their own names; only splits carry hub routing
   assign hub_addr_field = s.desc[W_DW1][HUB_ADDR_LSB +: 7];
   assign hub_port_field = s.desc[W_DW1][HUB_PORT_LSB +: 7];
   assign speed_end_field = s.desc[W_DW1][SPEED_END_LSB +: 2];
   assign token_field = s.desc[W_DW1][TOKEN_LSB +: 2];
   assign payload_buffer_addr = s.desc[W_DW2][BUF_ADDR_LSB +: 16];
   assign data_toggle_bit = s.desc[W_DW3][TOGGLE_POS];
   assign split_phase_flag = s.desc[W_DW3][PHASE_POS];
   assign poll_rate = s.desc[W_DW2][RATE_LSB +: 5];

   assign valid = s.desc[W_DW0][VALID_POS];
   assign active = s.desc[W_DW3][ACTIVE_POS];
   assign ttype = s.desc[W_DW1][TTYPE_LSB +: 2];
   assign is_split = s.desc[W_DW1][SPLIT_POS];
   assign cs_due = is_split & split_phase_flag;
   assign ss_mask = s.desc[W_DW4][SS_MASK_LSB +: 8];
   assign cs_mask = s.desc[W_DW5][CS_MASK_LSB +: 8];
   assign due_mask = cs_due ? cs_mask : ss_mask;

   poll_match u_poll
   (
      .rate(poll_rate),
      .frame(FRAME_MS),
      .hit(poll_hit)
   );

   // Next-state logic: register port, scheduling and write-back
   always_comb
   begin
      logic [31:0] w3;
      logic [31:0] w4;
      logic [31:0] w0;
      logic bab_any;
      logic xerr_any;
      logic fatal;
      logic finish;
      w3 = '0;
      w4 = '0;
      w0 = '0;
      bab_any = 1'b0;
      xerr_any = 1'b0;
      fatal = 1'b0;
      finish = 1'b0;
      next_s = s;
      next_s.rd_data = '0;

      // Software writes land first so hardware updates of this cycle win
      if (REG_WR && (REG_ADDR < ADDR_ENGINE))
      begin
         next_s.desc[REG_ADDR[2:0]] = REG_WDATA;
      end

      // Read data stands only in the cycle after the strobe
      if (REG_RD)
      begin
         if (REG_ADDR < ADDR_ENGINE)
         begin
            next_s.rd_data = s.desc[REG_ADDR[2:0]];
         end
         else if (REG_ADDR == ADDR_ENGINE)
         begin
            next_s.rd_data = {25'h0, s.slot, s.last_res, s.state == ST_WAIT};
         end
      end

      // Working copies: hardware updates are laid over the software write
      w0 = next_s.desc[W_DW0];
      w3 = next_s.desc[W_DW3];
      w4 = next_s.desc[W_DW4];

      case (s.state)
         ST_IDLE:
         begin
            // only scheduled microframes of matching frames issue
            if (SOF && valid && active && (ttype == TTYPE_INTR) && poll_hit
                && due_mask[UFRAME])
            begin
               next_s.state = ST_WAIT;
               next_s.req = 1'b1;
               next_s.slot = UFRAME;
               next_s.split = is_split;
               next_s.phase = cs_due;
               next_s.hub = is_split ? hub_addr_field : 7'h00;
               next_s.port = is_split ? hub_port_field : 7'h00;
               next_s.speed_end = is_split ? speed_end_field : 2'h0;
               next_s.pid = token_field;
               next_s.dev = s.desc[W_DW1][DEV_LSB +: 7];
               next_s.ep = {s.desc[W_DW1][EP_HIGH_LSB +: 3], s.desc[W_DW0][EP_LOW_POS]};
               next_s.toggle = data_toggle_bit;
               next_s.maxlen = s.desc[W_DW0][MAXPKT_LSB +: 11];
               next_s.buf_addr = payload_buffer_addr;
            end
         end
         ST_WAIT:
         begin
            // SOF is ignored here; a missed slot waits for its next frame
            if (XFER_DONE)
            begin
               next_s.state = ST_IDLE;
               next_s.req = 1'b0;
               next_s.last_res = XFER_RESULT;
               case (XFER_RESULT)
                  RES_ACK:
                  begin
                     if (s.split && !s.phase)
                     begin
                        // start split accepted, complete split due
                        w3[PHASE_POS] = 1'b1;
                     end
                     else
                     begin
                        w3[DONE_CNT_LSB +: 12] = XFER_COUNT;
                        w3[TOGGLE_POS] = ~s.toggle;
                        w3[PHASE_POS] = 1'b0;
                        finish = 1'b1;
                     end
                  end
                  RES_NAK:
                  begin
                     // Complete split refused: redo the start split
                     if (s.split && s.phase)
                     begin
                        w3[PHASE_POS] = 1'b0;
                     end
                  end
                  RES_NYET:
                  begin
                     // Try again at the next complete-split slot
                     w3[PHASE_POS] = s.phase;
                  end
                  RES_STALL:
                  begin
                     fatal = 1'b1;
                  end
                  RES_XERR:
                  begin
                     w4[RESULT_LSB + RESULT_W * s.slot + RES_XERR_BIT] = 1'b1;
                     if (w3[CERR_LSB +: 2] == CERR_NONE)
                     begin
                        fatal = 1'b1;
                     end
                     else
                     begin
                        w3[CERR_LSB +: 2] = w3[CERR_LSB +: 2] - 2'h1;
                     end
                  end
                  RES_BABBLE:
                  begin
                     w4[RESULT_LSB + RESULT_W * s.slot + RES_BABBLE_BIT] = 1'b1;
                     fatal = 1'b1;
                  end
                  RES_UNDERRUN:
                  begin
                     w4[RESULT_LSB + RESULT_W * s.slot + RES_UNDERRUN_BIT] = 1'b1;
                     fatal = 1'b1;
                  end
                  default:
                  begin
                     fatal = 1'b1;
                  end
               endcase
            end
         end
         default:
         begin
            next_s.state = ST_IDLE;
            next_s.req = 1'b0;
         end
      endcase

      if (fatal)
      begin
         w3[HALT_POS] = 1'b1;
      end

      // active cleared when the descriptor is finished
      if (fatal || finish)
      begin
         w3[ACTIVE_POS] = 1'b0;
         w0[VALID_POS] = 1'b0;
      end

      // Summaries follow the eight results, software writes included
      for (int k = 0; k < 8; k++)
      begin
         bab_any = bab_any | w4[RESULT_LSB + RESULT_W * k + RES_BABBLE_BIT];
         xerr_any = xerr_any | w4[RESULT_LSB + RESULT_W * k + RES_XERR_BIT];
      end
      w3[BABBLE_POS] = bab_any;
      w3[XERR_POS] = xerr_any;

      next_s.desc[W_DW0] = w0;
      next_s.desc[W_DW3] = w3;
      next_s.desc[W_DW4] = w4;
   end

   // State register
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         s <= '0;
         s.state <= ST_IDLE;
         s.desc <= {DESC_WORDS{DESC_RESET}};
      end
      else
      begin
         s <= next_s;
      end
   end

   // Outputs straight from the state flip-flops
   assign REG_RDATA = s.rd_data;
   assign XFER_REQ = s.req;
   assign XFER_SPLIT = s.split;
   assign XFER_PHASE = s.phase;
   assign XFER_HUB = s.hub;
   assign XFER_PORT = s.port;
   assign XFER_SPEED_END = s.speed_end;
   assign XFER_PID = s.pid;
   assign XFER_DEV = s.dev;
   assign XFER_EP = s.ep;
   assign XFER_TOGGLE = s.toggle;
   assign XFER_MAXLEN = s.maxlen;
   assign XFER_BUF_ADDR = s.buf_addr;
endmodule // split_intr_exec

// *** testbench/split_intr_exec_properties.sv ***
// Port-level assertions for the interrupt descriptor executor
`timescale 1ns/10ps
module split_intr_exec_properties
   import desc_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [3:0] REG_ADDR,
   input wire logic REG_RD,
   input wire logic [31:0] REG_RDATA,
   input wire logic SOF,
   input wire logic XFER_REQ,
   input wire logic XFER_SPLIT,
   input wire logic [6:0] XFER_HUB,
   input wire logic [6:0] XFER_PORT,
   input wire logic [1:0] XFER_SPEED_END,
   input wire logic XFER_TOGGLE,
   input wire logic [15:0] XFER_BUF_ADDR,
   input wire logic XFER_DONE
);
   // One clock domain, all checks idle while reset is low
   default clocking @(posedge CLK);
   endclocking
   default disable iff (!RST_N);

   property p_idle_out;
      $rose(RST_N) |-> !XFER_REQ && REG_RDATA == 32'h0;
   endproperty
   a_idle_out: assert property (p_idle_out) else $error("busy out of reset");
   property p_req_from_sof;
      $rose(XFER_REQ) |-> $past(SOF);
   endproperty
   a_req_from_sof: assert property (p_req_from_sof) else $error("req without sof");
   property p_req_holds;
      XFER_REQ && !XFER_DONE |=> XFER_REQ;
   endproperty
   a_req_holds: assert property (p_req_holds) else $error("req dropped early");
   property p_req_ends;
      XFER_REQ && XFER_DONE |=> !XFER_REQ;
   endproperty
   a_req_ends: assert property (p_req_ends) else $error("req kept after done");
   property p_fields_stand;
      XFER_REQ && !XFER_DONE |=> $stable(XFER_BUF_ADDR) && $stable(XFER_TOGGLE);
   endproperty
   a_fields_stand: assert property (p_fields_stand) else $error("fields moved");
   property p_hs_no_hub;
      XFER_REQ && !XFER_SPLIT |-> XFER_HUB == 7'h0 && XFER_PORT == 7'h0;
   endproperty
   a_hs_no_hub: assert property (p_hs_no_hub) else $error("hub on hs");
   property p_hs_no_se;
      XFER_REQ && !XFER_SPLIT |-> XFER_SPEED_END == 2'h0;
   endproperty
   a_hs_no_se: assert property (p_hs_no_se) else $error("speed on hs");
   property p_rdata_one;
      !REG_RD |=> REG_RDATA == 32'h0;
   endproperty
   a_rdata_one: assert property (p_rdata_one) else $error("read data lingers");
   property p_unmapped;
      REG_RD && REG_ADDR > ADDR_ENGINE |=> REG_RDATA == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read");
   property p_busy_seen;
      REG_RD && REG_ADDR == ADDR_ENGINE && XFER_REQ |=> REG_RDATA[0];
   endproperty
   a_busy_seen: assert property (p_busy_seen) else $error("busy not shown");
endmodule // split_intr_exec_properties

// *** testbench/xfer_engine_model.sv ***
// Behavioural packet engine facing the executor
`timescale 1ns/10ps
module xfer_engine_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic req,
   input wire logic [2:0] res,
   input wire logic [11:0] cnt,
   input wire logic [7:0] dly,
   output logic done,
   output logic [2:0] result,
   output logic [11:0] count
);
   logic [7:0] n;
   logic go;
   assign go = req && !done && n == dly;
   // Answer after dly cycles; one-cycle done pulse
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         n <= 8'h0;
         done <= 1'b0;
      end
      else
      begin
         done <= go;
         n <= (req && !done && !go) ? n + 8'h1 : 8'h0;
      end
   end
   // scrambled outside done so stale values never match
   assign result = done ? res : ~res;
   assign count = done ? cnt : ~cnt;
endmodule // xfer_engine_model

// *** testbench/testbench.sv ***
// Self-checking bench for the interrupt descriptor executor
`timescale 1ns/10ps
module testbench
   import desc_pkg::*;
;
   typedef struct packed {logic s; logic [2:0] r; logic [31:0] i, e, m; logic v;} row_s;
   localparam logic [31:0] W0 = 32'h0100_0001;
   localparam logic [15:0] HPS = {7'h3a, 7'h05, 2'h2};
   logic clk = 1'b0, rst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0, sof = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, w1;
   logic [2:0] uf = 3'h0, m_res = 3'h0, res;
   logic [4:0] fms = 5'h0;
   logic [11:0] m_cnt = 12'h040, cnt;
   logic [7:0] m_dly = 8'h0;
   logic req, spl, ph, tog, done;
   logic [6:0] hub, port, dev;
   logic [1:0] se, pid, tk;
   logic [3:0] ep;
   logic [10:0] maxl;
   logic [15:0] baddr;
   int fail_count = 0, n_checks = 0;
   row_s rows [10];

   split_intr_exec DUT (.CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
      .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdata), .SOF(sof), .UFRAME(uf),
      .FRAME_MS(fms), .XFER_REQ(req), .XFER_SPLIT(spl), .XFER_PHASE(ph), .XFER_HUB(hub),
      .XFER_PORT(port), .XFER_SPEED_END(se), .XFER_PID(pid), .XFER_DEV(dev), .XFER_EP(ep),
      .XFER_TOGGLE(tog), .XFER_MAXLEN(maxl), .XFER_BUF_ADDR(baddr), .XFER_DONE(done),
      .XFER_RESULT(res), .XFER_COUNT(cnt));
   xfer_engine_model u_eng (.clk(clk), .rst_n(rst_n), .req(req), .res(m_res), .cnt(m_cnt),
      .dly(m_dly), .done(done), .result(res), .count(cnt));

   // Free-running 200 MHz clock
   initial
   begin
      forever #2.5 clk = ~clk;
   end

   task automatic final_report;
      $display("checks %0d failures %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Watchdog far beyond the few hundred cycles expected
   initial
   begin
      #100000;
      fail_count++;
      final_report;
   end

   task automatic cmp(input logic [63:0] g, input logic [63:0] x);
      n_checks++;
      if (g !== x)
      begin
         fail_count++;
         $display("CHECK FAILED %0t got %h exp %h", $time, g, x);
      end
   endtask

   // Strobe stays up between writes, so no double assignment
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
   endtask

   task automatic rdc(input logic [3:0] a, input logic [31:0] x, input logic [31:0] k = '1);
      addr <= a;
      wr_s <= 1'b0;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      // Read data stands only in the cycle after the strobe edge
      #1 cmp({32'h0, rdata & k}, {32'h0, x});
   endtask

   task automatic load(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
      wr(4'h0, W0);
      wr(4'h1, a);
      wr(4'h2, b);
      wr(4'h3, c);
      wr(4'h4, 32'hff);
      wr(4'h5, 32'hff);
      wr_s <= 1'b0;
   endtask

   task automatic fire(input logic [2:0] u, input logic [4:0] f, input logic x);
      uf <= u;
      fms <= f;
      sof <= 1'b1;
      @(posedge clk);
      sof <= 1'b0;
      #1 cmp({63'h0, req}, {63'h0, x});
   endtask

   // Bounded wait; the descriptor is written back as the request drops
   task automatic fin;
      for (int k = 0; k < 300 && req !== 1'b0; k++)
      begin
         @(posedge clk);
         #1;
      end
      // A request that never ends counts as a mismatch
      if (req !== 1'b0)
      begin
         fail_count++;
         $display("CHECK FAILED %0t request never ended", $time);
      end
   endtask

   initial
   begin
      rows = '{'{1'b0, RES_ACK, 32'h8180_0000, 32'h0380_0040, 32'hff, 1'b0},
         '{1'b1, RES_ACK, 32'h8180_0000, 32'h8980_0000, 32'hff, 1'b1},
         '{1'b1, RES_ACK, 32'h8b80_0000, 32'h0180_0040, 32'hff, 1'b0},
         '{1'b1, RES_NAK, 32'h8980_0000, 32'h8180_0000, 32'hff, 1'b1},
         '{1'b1, RES_NYET, 32'h8980_0000, 32'h8980_0000, 32'hff, 1'b1},
         '{1'b0, RES_STALL, 32'h8180_0000, 32'h4180_0000, 32'hff, 1'b0},
         '{1'b1, RES_BABBLE, 32'h8180_0000, 32'h6180_0000, 32'h2ff, 1'b0},
         '{1'b1, RES_UNDERRUN, 32'h8180_0000, 32'h4180_0000, 32'h4ff, 1'b0},
         '{1'b0, RES_XERR, 32'h8180_0000, 32'h9100_0000, 32'h1ff, 1'b1},
         '{1'b0, 3'h7, 32'h8180_0000, 32'h4180_0000, 32'hff, 1'b0}};
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      rdc(4'h3, 32'h0);
      wr(4'h8, 32'hffff_ffff);
      rdc(4'h8, 32'h0);
      rdc(4'h9, 32'h0);
      $display("reset test done");
      // One outcome per row, engine delay grows row by row
      for (int i = 0; i < 10; i++)
      begin
         tk = rows[i].r == RES_UNDERRUN ? TOKEN_OUT : TOKEN_IN;
         w1 = {HPS, 1'b0, rows[i].s, TTYPE_INTR, tk, 7'h11, 3'h1};
         m_res <= rows[i].r;
         m_dly <= 8'(i);
         load(w1, 32'h0012_3400, rows[i].i);
         fire(3'h0, 5'(i), 1'b1);
         cmp({5'h0, spl, ph, hub, port, se, pid, tog, baddr, dev, ep, maxl},
            {5'h0, rows[i].s, rows[i].i[27], HPS & {16{rows[i].s}}, tk, rows[i].i[25],
            16'h1234, 7'h11, 4'h2, 11'h040});
         fin;
         rdc(4'h3, rows[i].e);
         rdc(4'h4, rows[i].m);
         rdc(4'h0, {W0[31:1], rows[i].v});
         $display("row %0d done", i);
      end
      // Inactive descriptor, poll interval of 4 ms, microframe mask
      m_res <= RES_ACK;
      w1 = {HPS, 2'h0, TTYPE_INTR, TOKEN_OUT, 7'h11, 3'h1};
      load(w1, 32'h0012_3420, 32'h0180_0000);
      fire(3'h0, 5'h08, 1'b0);
      wr(4'h3, 32'h8180_0000);
      wr(4'h4, 32'h04);
      wr_s <= 1'b0;
      fire(3'h0, 5'h05, 1'b0);
      fire(3'h0, 5'h08, 1'b0);
      fire(3'h2, 5'h08, 1'b1);
      fin;
      rdc(4'h3, 32'h0380_0040);
      $display("poll test done");
      // Budget of one retry runs out on the second error
      m_res <= RES_XERR;
      m_dly <= 8'h14;
      load(w1, 32'h0012_3400, 32'h8080_0000);
      fire(3'h1, 5'h00, 1'b1);
      rdc(4'h8, 32'h1, 32'h1);
      fin;
      rdc(4'h3, 32'h9000_0000);
      fire(3'h1, 5'h00, 1'b1);
      fin;
      rdc(4'h3, 32'h5000_0000, 32'h7000_0000);
      $display("retry test done");
      // Other transfer types are never issued
      m_res <= RES_ACK;
      w1 = {HPS, 2'h0, 2'h2, TOKEN_OUT, 7'h11, 3'h1};
      load(w1, 32'h0012_3400, 32'h8180_0000);
      fire(3'h0, 5'h00, 1'b0);
      rdc(4'h3, 32'h8180_0000);
      $display("type test done");
      final_report;
   end
endmodule // testbench

bind split_intr_exec split_intr_exec_properties u_props (.CLK(CLK), .RST_N(RST_N),
   .REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .SOF(SOF),
   .XFER_REQ(XFER_REQ), .XFER_SPLIT(XFER_SPLIT), .XFER_HUB(XFER_HUB), .XFER_PORT(XFER_PORT),
   .XFER_SPEED_END(XFER_SPEED_END), .XFER_TOGGLE(XFER_TOGGLE),
   .XFER_BUF_ADDR(XFER_BUF_ADDR), .XFER_DONE(XFER_DONE));
